// ===== core/pcs_cfg.svh
`ifndef PCS_CFG_SVH
`define PCS_CFG_SVH

// register offsets on the serial port register map
`define PCS_ADDR_PLL_CFG 8'h04
`define PCS_ADDR_CLK_OUT 8'h06

// pll_and_adc_clock_config fields
`define PCS_PLL_M_LSB 0
`define PCS_PLL_N_LSB 2
`define PCS_PLL_ADC_SEL_BIT 4
`define PCS_PLL_CFG_RESET 8'h00
`define PCS_PLL_CFG_MASK 8'h1f

// clock_output_config fields
`define PCS_OUT1_DIS_BIT 0
`define PCS_OUT1_INV_BIT 1
`define PCS_OUT1_DIV_LSB 2
`define PCS_OUT2_DIS_BIT 4
`define PCS_OUT2_INV_BIT 5
`define PCS_OUT2_DIV_LSB 6
`define PCS_CLK_OUT_RESET 8'h00

// largest legal exponents
`define PCS_N_MAX 2'h2
`define PCS_L_MAX 2'h2

// reference period measurement
`define PCS_PERIOD_W 16
`define PCS_PERIOD_SAT 16'hffff
`define PCS_CHAIN_W 8

`endif

// ===== core/pcs_pkg.sv
package pcs_pkg;

    // divider, invert and disable of one clock output
    typedef struct packed {
        logic [1:0] div;
        logic inv;
        logic dis;
    } pcs_out_cfg_s;

    // reference lock progress
    typedef enum logic [1:0] {
        PCS_LK_IDLE,
        PCS_LK_MEASURE,
        PCS_LK_LOCKED
    } pcs_lock_e;

endpackage

// ===== core/pcs_clock_synth.sv
// What this block does
// R1: dac clock is reference times two to M
// R2: adc clock source bit selects reference or vco
// R3: vco path divides by two to N, N<=2
// R4: tx, rx and adc word rates kept equal; here adc rate is set by its source bit and N, not tied to the word rate
// R5: dac rate one, two or four word rates
// R6: full duplex receive clock twice word rate, held to the dac rate with no interpolation
// R7: software picks M from interpolation and rates
// R8: software keeps reference and vco in range
// R9: first output is dac clock over two to R
// R10: first output shares pll dividers, fixed phase
// R11: second output is reference over two to L
// R12: L zero copies reference, else free divider
// R13: per output invert and disable bits
// R14: outputs keep toggling through reset and soft reset
// R15: power down leaves pll and outputs running
// R16: setting changes never produce runt pulses; here only the two programmable outputs are gated
`timescale 1ns/100ps
`default_nettype none
`include "pcs_cfg.svh"

module pcs_clock_synth (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_por,
    input wire logic i_soft_rst,
    input wire logic i_reference_clock_in,
    input wire logic i_full_duplex,
    input wire logic [1:0] i_interp_factor,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    output logic o_crystal_drive_pin,
    output logic o_dac_update_clock,
    output logic o_adc_sample_clock,
    output logic o_receive_clock_out,
    output logic o_vco_derived_clock_out,
    output logic o_reference_derived_clock_out,
    output logic o_pll_locked
);

    // level of vco divided by two to k, taken from the shared chain
    function automatic logic pcs_div(input logic vco, input logic [`PCS_CHAIN_W-1:0] chain,
                                     input logic [1:0] k);
        pcs_div = (k == 2'h0) ? vco : chain[k - 2'h1];
    endfunction

    // clamp an exponent to its largest legal value
    function automatic logic [1:0] pcs_clamp(input logic [1:0] v, input logic [1:0] vmax);
        pcs_clamp = (v > vmax) ? vmax : v;
    endfunction

    // output level for a given source and setting
    function automatic logic pcs_level(input logic src, input pcs_pkg::pcs_out_cfg_s c);
        pcs_level = c.dis ? 1'b0 : (src ^ c.inv);
    endfunction

    // vco half period in mclk cycles, never below one
    function automatic logic [`PCS_PERIOD_W-1:0] pcs_half(input logic [`PCS_PERIOD_W-1:0] p,
                                                          input logic [1:0] m);
        logic [`PCS_PERIOD_W-1:0] h;
        h = p >> ({1'b0, m} + 3'h1);
        pcs_half = (h == '0) ? `PCS_PERIOD_W'(1) : h;
    endfunction

    logic [7:0] pll_cfg_reg, pll_cfg_next;
    logic [7:0] clk_out_reg, clk_out_next;
    logic [7:0] rdata_reg, rdata_next;
    logic ref_q_reg, ref_prev_reg;
    logic ref_rise;
    pcs_pkg::pcs_lock_e lock_reg, lock_next;
    logic [`PCS_PERIOD_W-1:0] per_cnt_reg, per_cnt_next;
    logic [`PCS_PERIOD_W-1:0] period_reg, period_next;
    logic [`PCS_PERIOD_W-1:0] vco_cnt_reg, vco_cnt_next;
    logic [`PCS_PERIOD_W-1:0] half;
    logic vco_reg, vco_next;
    logic [`PCS_CHAIN_W-1:0] chain_reg, chain_next;
    logic [1:0] ref_div_reg, ref_div_next;
    pcs_pkg::pcs_out_cfg_s act1_reg, act1_next, act2_reg, act2_next;
    pcs_pkg::pcs_out_cfg_s new1, new2;
    logic src1_old, src1_new, src2_old, src2_new;
    logic out1_reg, out1_next, out2_reg, out2_next;
    logic dac_reg, dac_next, adc_reg, adc_next, rx_reg, rx_next, crystal_drive_pin_reg, crystal_drive_pin_next;
    logic [1:0] log2f, rx_k, m_sel, n_sel;
    logic cfg_rst;
    logic locked_reg, locked_next;

    // both resets clear only the configuration and read data, never the clock generators
    assign cfg_rst = i_rst | i_soft_rst; // R14

    // register file writes and registered read data
    always_comb begin
        pll_cfg_next = pll_cfg_reg;
        clk_out_next = clk_out_reg;
        rdata_next = rdata_reg;
        if (i_reg_wr && i_reg_addr == `PCS_ADDR_PLL_CFG) begin
            pll_cfg_next = i_reg_wdata & `PCS_PLL_CFG_MASK;
        end
        if (i_reg_wr && i_reg_addr == `PCS_ADDR_CLK_OUT) begin
            clk_out_next = i_reg_wdata;
        end
        if (i_reg_rd) begin
            case (i_reg_addr)
                `PCS_ADDR_PLL_CFG: rdata_next = pll_cfg_reg;
                `PCS_ADDR_CLK_OUT: rdata_next = clk_out_reg;
                default: rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_mclk) begin
        if (cfg_rst) begin
            pll_cfg_reg <= `PCS_PLL_CFG_RESET;
            clk_out_reg <= `PCS_CLK_OUT_RESET;
            rdata_reg <= 8'h00;
        end else begin
            pll_cfg_reg <= pll_cfg_next;
            clk_out_reg <= clk_out_next;
            rdata_reg <= rdata_next;
        end
    end

    // decoded settings
    assign m_sel = pll_cfg_reg[`PCS_PLL_M_LSB +: 2]; // R1
    assign n_sel = pcs_clamp(pll_cfg_reg[`PCS_PLL_N_LSB +: 2], `PCS_N_MAX); // R3
    assign new1.div = clk_out_reg[`PCS_OUT1_DIV_LSB +: 2]; // R9
    assign new1.inv = clk_out_reg[`PCS_OUT1_INV_BIT]; // R13
    assign new1.dis = clk_out_reg[`PCS_OUT1_DIS_BIT]; // R13
    assign new2.div = pcs_clamp(clk_out_reg[`PCS_OUT2_DIV_LSB +: 2], `PCS_L_MAX); // R11
    assign new2.inv = clk_out_reg[`PCS_OUT2_INV_BIT]; // R13
    assign new2.dis = clk_out_reg[`PCS_OUT2_DIS_BIT]; // R13

    // reference edge detect; the pin is taken as synchronous
    assign ref_rise = ref_q_reg & ~ref_prev_reg;
    assign half = pcs_half(period_reg, m_sel);

    // lock tracking: measure the reference period between rising edges
    always_comb begin
        lock_next = lock_reg;
        period_next = period_reg;
        per_cnt_next = (per_cnt_reg == `PCS_PERIOD_SAT) ? per_cnt_reg : per_cnt_reg + 1'b1;
        if (ref_rise) begin
            per_cnt_next = '0;
            period_next = per_cnt_reg + 1'b1;
            case (lock_reg)
                pcs_pkg::PCS_LK_IDLE: lock_next = pcs_pkg::PCS_LK_MEASURE;
                pcs_pkg::PCS_LK_MEASURE: lock_next = pcs_pkg::PCS_LK_LOCKED;
                pcs_pkg::PCS_LK_LOCKED: lock_next = pcs_pkg::PCS_LK_LOCKED;
                default: lock_next = pcs_pkg::PCS_LK_IDLE;
            endcase
        end else if (per_cnt_reg == `PCS_PERIOD_SAT) begin
            // reference gone: drop lock rather than run on a stale period
            lock_next = pcs_pkg::PCS_LK_IDLE;
        end
        locked_next = (lock_next == pcs_pkg::PCS_LK_LOCKED);
    end

    // power-on only; power down and resets leave the pll running
    always_ff @(posedge i_mclk) begin // R15
        if (i_por) begin
            lock_reg <= pcs_pkg::PCS_LK_IDLE;
            per_cnt_reg <= '0;
            period_reg <= '0;
            ref_q_reg <= 1'b0;
            ref_prev_reg <= 1'b0;
            locked_reg <= 1'b0;
        end else begin
            lock_reg <= lock_next;
            per_cnt_reg <= per_cnt_next;
            period_reg <= period_next;
            ref_q_reg <= i_reference_clock_in;
            ref_prev_reg <= ref_q_reg;
            locked_reg <= locked_next;
        end
    end

    // vco: toggles every half period, realigned to each reference edge so
    // the shared divider chain keeps a fixed phase to the reference
    always_comb begin
        vco_next = vco_reg;
        vco_cnt_next = vco_cnt_reg + 1'b1;
        chain_next = chain_reg;
        ref_div_next = ref_rise ? ref_div_reg + 2'h1 : ref_div_reg; // R12
        if (lock_reg != pcs_pkg::PCS_LK_LOCKED) begin
            vco_next = 1'b0;
            vco_cnt_next = '0;
            chain_next = '0;
        end else if (ref_rise) begin
            vco_next = 1'b1; // R1
            vco_cnt_next = '0;
            // the realigning edge is a vco rise too; the chain keeps counting
            // so outputs slower than the reference still divide
            if (!vco_reg) begin
                chain_next = chain_reg + 1'b1; // R10
            end
        end else if (vco_cnt_reg >= half - 1'b1) begin
            vco_next = ~vco_reg; // R1
            vco_cnt_next = '0;
            if (!vco_reg) begin
                chain_next = chain_reg + 1'b1; // R10
            end
        end
    end

    always_ff @(posedge i_mclk) begin // R14
        if (i_por) begin
            vco_reg <= 1'b0;
            vco_cnt_reg <= '0;
            chain_reg <= '0;
            ref_div_reg <= 2'h0;
        end else begin
            vco_reg <= vco_next;
            vco_cnt_reg <= vco_cnt_next;
            chain_reg <= chain_next;
            ref_div_reg <= ref_div_next;
        end
    end

    // interpolation 1, 2 or 4 gives the word rate as dac rate over 2^log2f
    always_comb begin
        case (i_interp_factor)
            2'h0: log2f = 2'h0;
            2'h1: log2f = 2'h1;
            default: log2f = 2'h2;
        endcase
        // full duplex moves nibbles, so one octave above the word rate;
        // with no interpolation that would exceed the vco and is clamped
        if (i_full_duplex) begin
            rx_k = (log2f == 2'h0) ? 2'h0 : log2f - 2'h1; // R6
        end else begin
            rx_k = log2f; // R4
        end
    end

    // internal sampling clocks and crystal inverter drive
    always_comb begin
        dac_next = vco_reg; // R5
        if (pll_cfg_reg[`PCS_PLL_ADC_SEL_BIT]) begin
            adc_next = pcs_div(vco_reg, chain_reg, n_sel); // R2 R3
        end else begin
            adc_next = ref_q_reg; // R2
        end
        rx_next = pcs_div(vco_reg, chain_reg, rx_k); // R6
        crystal_drive_pin_next = ~ref_q_reg;
    end

    // programmable outputs: a new setting is adopted only while the pin is
    // low and its new level is low, so no short high escapes; an invert flip
    // can still be taken, at the price of one stretched low phase
    always_comb begin
        src1_old = pcs_div(vco_reg, chain_reg, act1_reg.div); // R9 R10
        src1_new = pcs_div(vco_reg, chain_reg, new1.div);
        case (act2_reg.div)
            2'h0: src2_old = ref_q_reg; // R12
            2'h1: src2_old = ref_div_reg[0]; // R11
            default: src2_old = ref_div_reg[1]; // R11
        endcase
        case (new2.div)
            2'h0: src2_new = ref_q_reg;
            2'h1: src2_new = ref_div_reg[0];
            default: src2_new = ref_div_reg[1];
        endcase
        act1_next = act1_reg;
        act2_next = act2_reg;
        out1_next = pcs_level(src1_old, act1_reg); // R13
        out2_next = pcs_level(src2_old, act2_reg); // R13
        if (act1_reg != new1 && !out1_reg && !pcs_level(src1_new, new1)) begin
            act1_next = new1; // R16
            out1_next = 1'b0;
        end
        if (act2_reg != new2 && !out2_reg && !pcs_level(src2_new, new2)) begin
            act2_next = new2; // R16
            out2_next = 1'b0;
        end
    end

    // clock outputs ride only the power-on reset so they run through resets
    always_ff @(posedge i_mclk) begin // R14
        if (i_por) begin
            act1_reg <= '0;
            act2_reg <= '0;
            out1_reg <= 1'b0;
            out2_reg <= 1'b0;
            dac_reg <= 1'b0;
            adc_reg <= 1'b0;
            rx_reg <= 1'b0;
            crystal_drive_pin_reg <= 1'b1;
        end else begin
            act1_reg <= act1_next;
            act2_reg <= act2_next;
            out1_reg <= out1_next;
            out2_reg <= out2_next;
            dac_reg <= dac_next;
            adc_reg <= adc_next;
            rx_reg <= rx_next;
            crystal_drive_pin_reg <= crystal_drive_pin_next;
        end
    end

    assign o_reg_rdata = rdata_reg;
    assign o_crystal_drive_pin = crystal_drive_pin_reg;
    assign o_dac_update_clock = dac_reg;
    assign o_adc_sample_clock = adc_reg;
    assign o_receive_clock_out = rx_reg;
    assign o_vco_derived_clock_out = out1_reg;
    assign o_reference_derived_clock_out = out2_reg;
    assign o_pll_locked = locked_reg;

endmodule

`default_nettype wire

// ===== tb/pcs_clock_synth_properties.sv
`timescale 1ns/100ps
`default_nettype none
module pcs_clock_synth_properties (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_por,
    input wire logic i_soft_rst,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [7:0] o_reg_rdata,
    input wire logic o_vco_derived_clock_out,
    input wire logic o_reference_derived_clock_out
);
    logic [7:0] pll_reg, pll_next, out_reg, out_next;
    logic clr, quiet;
    // quiet: no reset and no write that could move a setting
    assign clr = i_rst | i_soft_rst;
    assign quiet = !clr && !i_reg_wr && !i_por;
    // shadow copies of both registers
    always_comb begin
        pll_next = pll_reg;
        out_next = out_reg;
        if (i_reg_wr && i_reg_addr == 8'h04) begin
            pll_next = i_reg_wdata & 8'h1f;
        end
        if (i_reg_wr && i_reg_addr == 8'h06) begin
            out_next = i_reg_wdata;
        end
        if (clr) begin
            pll_next = 8'h00;
            out_next = 8'h00;
        end
    end
    always_ff @(posedge i_mclk) begin
        pll_reg <= pll_next;
        out_reg <= out_next;
    end
    default clocking @(posedge i_mclk);
    endclocking
    a_unmapped_reads_zero: assert property (disable iff (clr)
        i_reg_rd && i_reg_addr != 8'h04 && i_reg_addr != 8'h06 |=> o_reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_read_pll_cfg: assert property (disable iff (clr)
        i_reg_rd && i_reg_addr == 8'h04 |=> o_reg_rdata == $past(pll_reg))
        else $error("pll config readback wrong");
    a_read_out_cfg: assert property (disable iff (clr)
        i_reg_rd && i_reg_addr == 8'h06 |=> o_reg_rdata == $past(out_reg))
        else $error("clock output readback wrong");
    a_rdata_holds: assert property (disable iff (clr)
        !i_reg_rd |=> $stable(o_reg_rdata))
        else $error("read data moved without a read");
    a_out1_stays_off: assert property (disable iff (i_por)
        (quiet && out_reg[0] && !o_vco_derived_clock_out)[*2] |=> !o_vco_derived_clock_out)
        else $error("disabled first output rose");
    a_out2_stays_off: assert property (disable iff (i_por)
        (quiet && out_reg[4] && !o_reference_derived_clock_out)[*2]
        |=> !o_reference_derived_clock_out)
        else $error("disabled second output rose");
    a_out1_keeps_toggling: assert property (disable iff (i_por)
        $rose(o_vco_derived_clock_out) |-> ##[1:300] $fell(o_vco_derived_clock_out))
        else $error("first output stuck high");
    a_out2_keeps_toggling: assert property (disable iff (i_por)
        $rose(o_reference_derived_clock_out) |-> ##[1:200] $fell(o_reference_derived_clock_out))
        else $error("second output stuck high");
endmodule
bind pcs_clock_synth pcs_clock_synth_properties u_props (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_por(i_por),
    .i_soft_rst(i_soft_rst),
    .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd),
    .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata),
    .o_vco_derived_clock_out(o_vco_derived_clock_out),
    .o_reference_derived_clock_out(o_reference_derived_clock_out)
);
`default_nettype wire

// ===== tb/pcs_ref_src.sv
`timescale 1ns/100ps
`default_nettype none
// external reference oscillator, crystal pin left open
module pcs_ref_src #(
    parameter int HALF_NS = 320
) (
    output logic o_ref
);
    // free running and slow against the system clock; odd start offset
    // keeps its edges away from the sampling edge
    initial begin
        o_ref = 1'b0;
        #7;
        forever #(HALF_NS) o_ref = ~o_ref;
    end
endmodule
`default_nettype wire

// ===== tb/pll_clock_synthesizer_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module pll_clock_synthesizer_tb_top;
    logic i_mclk = 1'b0;
    logic i_rst = 1'b1;
    logic i_por = 1'b1;
    logic i_soft_rst = 1'b0;
    logic i_full_duplex = 1'b0;
    logic [1:0] i_interp_factor = 2'h0;
    logic i_reg_wr = 1'b0;
    logic i_reg_rd = 1'b0;
    logic [7:0] i_reg_addr = 8'h00;
    logic [7:0] i_reg_wdata = 8'h00;
    logic i_reference_clock_in, o_crystal_drive_pin, o_pll_locked;
    logic o_dac_update_clock, o_adc_sample_clock, o_receive_clock_out;
    logic o_vco_derived_clock_out, o_reference_derived_clock_out;
    logic [7:0] o_reg_rdata;
    logic [7:0] pins;
    logic [4:0] cur, prev = 5'h00;
    logic [7:0] pv[7] = '{8'h00, 8'h01, 8'h1a, 8'h1a, 8'h17, 8'h1e, 8'h09};
    logic [7:0] ov[7] = '{8'h00, 8'h44, 8'h88, 8'h0c, 8'h11, 8'h33, 8'hc0};
    logic [1:0] iv[7] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h2, 2'h0, 2'h1};
    logic [6:0] fv = 7'h68;
    int cnt[5];
    int err_total = 0;
    int checks = 0;
    assign cur = {o_dac_update_clock, o_adc_sample_clock, o_receive_clock_out,
        o_vco_derived_clock_out, o_reference_derived_clock_out};
    // both programmable outputs and the crystal drive, for phase checks
    assign pins = {5'h00, o_vco_derived_clock_out, o_reference_derived_clock_out,
        o_crystal_drive_pin};
    pcs_ref_src src (.o_ref(i_reference_clock_in));
    pcs_clock_synth dut (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_por(i_por),
        .i_soft_rst(i_soft_rst),
        .i_reference_clock_in(i_reference_clock_in),
        .i_full_duplex(i_full_duplex),
        .i_interp_factor(i_interp_factor),
        .i_reg_wr(i_reg_wr),
        .i_reg_rd(i_reg_rd),
        .i_reg_addr(i_reg_addr),
        .i_reg_wdata(i_reg_wdata),
        .o_reg_rdata(o_reg_rdata),
        .o_crystal_drive_pin(o_crystal_drive_pin),
        .o_dac_update_clock(o_dac_update_clock),
        .o_adc_sample_clock(o_adc_sample_clock),
        .o_receive_clock_out(o_receive_clock_out),
        .o_vco_derived_clock_out(o_vco_derived_clock_out),
        .o_reference_derived_clock_out(o_reference_derived_clock_out),
        .o_pll_locked(o_pll_locked)
    );
    initial begin
        forever #10 i_mclk = ~i_mclk;
    end
    // tol 1 allows a clock edge cut by either end of the window
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input int tol);
        checks++;
        if ($isunknown(got) || (got !== exp && (tol == 0 || got > exp + 1 || got + 1 < exp))) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // quiet cycle after each strobe so two strobes never meet
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_reg_addr = a;
        i_reg_wdata = d;
        i_reg_wr = 1'b1;
        @(posedge i_mclk);
        #1;
        i_reg_wr = 1'b0;
        @(posedge i_mclk);
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        i_reg_addr = a;
        i_reg_rd = 1'b1;
        @(posedge i_mclk);
        #1;
        i_reg_rd = 1'b0;
        chk(o_reg_rdata, e, 0);
        @(posedge i_mclk);
        #1;
    endtask
    // count rises over eight reference periods against the settings
    task automatic rates(input logic [7:0] p, input logic [7:0] o);
        int dac, f, e[5];
        dac = 8 << p[1:0];
        f = (i_interp_factor == 2'h0) ? 1 : (i_interp_factor == 2'h1) ? 2 : 4;
        e[4] = dac;
        e[3] = p[4] ? dac >> ((p[3:2] > 2'h2) ? 2 : p[3:2]) : 8;
        e[2] = i_full_duplex ? ((f == 1) ? dac : 2 * dac / f) : dac / f;
        e[1] = o[0] ? 0 : dac >> o[3:2];
        e[0] = o[4] ? 0 : 8 >> ((o[7:6] > 2'h2) ? 2 : o[7:6]);
        cnt = '{default: 0};
        repeat (160) @(posedge i_mclk);
        #1;
        prev = cur; // no stale level from the previous setting
        for (int i = 0; i < 256; i++) begin
            @(posedge i_mclk);
            #1;
            for (int k = 0; k < 5; k++) begin
                cnt[k] += (cur[k] && !prev[k]) ? 1 : 0;
            end
            prev = cur;
        end
        for (int k = 0; k < 5; k++) begin
            chk(cnt[k][7:0], e[k][7:0], 1);
        end
    endtask
    // outputs sampled mid high and mid low of the reference
    // M=0 and R=0 so the first output runs at the reference rate
    task automatic phase(input logic inv);
        wr(8'h04, 8'h00);
        wr(8'h06, {2'h0, inv, 3'h0, inv, 1'b0});
        repeat (160) @(posedge i_mclk);
        @(posedge i_reference_clock_in);
        repeat (10) @(posedge i_mclk);
        #1;
        chk({7'h00, o_pll_locked}, 8'h01, 0);
        chk(pins, {5'h00, {2{~inv}}, 1'b0}, 0);
        repeat (16) @(posedge i_mclk);
        #1;
        chk(pins, {5'h00, {2{inv}}, 1'b1}, 0);
    endtask
    task automatic results();
        $display("checks=%0d errors=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // main sequence; M follows log2 of the interpolation, so ref equals word rate, except at i=4 and i=5
    initial begin
        repeat (3) @(posedge i_mclk);
        #1;
        i_rst = 1'b0;
        i_por = 1'b0;
        rd(8'h04, 8'h00);
        rd(8'h06, 8'h00);
        wr(8'h04, 8'hff);
        rd(8'h04, 8'h1f);
        wr(8'h05, 8'hff);
        rd(8'h05, 8'h00);
        for (int i = 0; i < 7; i++) begin
            wr(8'h04, pv[i]);
            wr(8'h06, ov[i]);
            i_full_duplex = fv[i];
            i_interp_factor = iv[i];
            rates(pv[i], ov[i]);
        end
        phase(1'b0);
        phase(1'b1);
        for (int s = 0; s < 2; s++) begin
            wr(8'h06, 8'h44);
            i_rst = (s == 0);
            i_soft_rst = (s == 1);
            rates(8'h00, 8'h00);
            i_rst = 1'b0;
            i_soft_rst = 1'b0;
            rd(8'h06, 8'h00);
        end
        results();
    end
    // watchdog: the sequence needs some 4200 cycles
    initial begin
        repeat (20000) @(posedge i_mclk);
        err_total++;
        results();
    end
endmodule
`default_nettype wire
